// ---- inc/ebtc_defines.vh ----
`ifndef EBTC_DEFINES_VH
`define EBTC_DEFINES_VH

// ********************************************************************
// Register byte offsets
// ********************************************************************
`define EBTC_OFS_CTRL_A 8'h00
`define EBTC_OFS_CTRL 8'h04
`define EBTC_OFS_COUNT 8'h08
`define EBTC_OFS_CMP_A 8'h0C
`define EBTC_OFS_FLAG 8'h10
`define EBTC_OFS_MASK 8'h14

// ********************************************************************
// Field positions
// ********************************************************************
`define EBTC_A_WGM_LSB 0
`define EBTC_A_COM_LSB 4
`define EBTC_A_FOC_BIT 7
`define EBTC_C_CS_LSB 0
`define EBTC_C_AS_BIT 3
`define EBTC_F_OVF_BIT 0
`define EBTC_F_CMP_BIT 1

// ********************************************************************
// Reset values and extreme counts
// ********************************************************************
`define EBTC_RST_BYTE 8'h00
`define EBTC_MAX 8'hFF
`define EBTC_BOTTOM 8'h00
`define EBTC_ONE 8'h01

// ********************************************************************
// Waveform modes and compare output actions
// ********************************************************************
`define EBTC_MODE_NORMAL 2'h0
`define EBTC_MODE_PHASE 2'h1
`define EBTC_MODE_CLR 2'h2
`define EBTC_MODE_FAST 2'h3
`define EBTC_ACT_NONE 2'h0
`define EBTC_ACT_TOGGLE 2'h1
`define EBTC_ACT_CLEAR 2'h2
`define EBTC_ACT_SET 2'h3

// ********************************************************************
// Prescaler terminal masks
// ********************************************************************
`define EBTC_PRE_W 10
`define EBTC_DIV1_MASK 10'h000
`define EBTC_DIV8_MASK 10'h007
`define EBTC_DIV32_MASK 10'h01F
`define EBTC_DIV64_MASK 10'h03F
`define EBTC_DIV128_MASK 10'h07F
`define EBTC_DIV256_MASK 10'h0FF
`define EBTC_DIV1024_MASK 10'h3FF

`endif

// ---- rtl/ebtc_tick.v ----
`timescale 1ns/1ns
`include "ebtc_defines.vh"

module ebtc_tick
(
   input wire hclk,                   // System clock
   input wire hresetn,                // Async reset, active low
   input wire [2:0] clock_source_select, // Prescale select, 0 stops
   input wire async_clock_select,     // 1 counts crystal edges
   input wire crystal_in_pin,         // Crystal input
   output reg timer_tick,             // One-cycle timer tick
   output reg crystal_out_pin         // Oscillator feedback
);

   reg xtal_meta;
   reg xtal_sync;
   reg xtal_prev;
   reg [`EBTC_PRE_W-1:0] prescale;
   wire src_edge;
   wire [`EBTC_PRE_W-1:0] div_mask;

   function [`EBTC_PRE_W-1:0] ebtc_div_mask;
      input [2:0] sel;
      begin
         case (sel)
            3'h2: ebtc_div_mask = `EBTC_DIV8_MASK;
            3'h3: ebtc_div_mask = `EBTC_DIV32_MASK;
            3'h4: ebtc_div_mask = `EBTC_DIV64_MASK;
            3'h5: ebtc_div_mask = `EBTC_DIV128_MASK;
            3'h6: ebtc_div_mask = `EBTC_DIV256_MASK;
            3'h7: ebtc_div_mask = `EBTC_DIV1024_MASK;
            default: ebtc_div_mask = `EBTC_DIV1_MASK;
         endcase
      end
   endfunction

   assign div_mask = ebtc_div_mask(clock_source_select);
   // Crystal edges are brought into the bus clock, so flags and CPU
   // updates all happen in one domain
   assign src_edge = async_clock_select ?
                     (xtal_sync & ~xtal_prev) : 1'b1;

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         xtal_meta <= 1'b0;
         xtal_sync <= 1'b0;
         xtal_prev <= 1'b0;
         crystal_out_pin <= 1'b0;
         prescale <= {`EBTC_PRE_W{1'b0}};
         timer_tick <= 1'b0;
      end
      else
      begin
         xtal_meta <= crystal_in_pin;
         xtal_sync <= xtal_meta;
         xtal_prev <= xtal_sync;
         crystal_out_pin <= ~xtal_sync;
         if (clock_source_select == 3'h0)
         begin
            prescale <= {`EBTC_PRE_W{1'b0}};
            timer_tick <= 1'b0;
         end
         else if (src_edge)
         begin
            prescale <= prescale + {{(`EBTC_PRE_W-1){1'b0}}, 1'b1};
            timer_tick <= ((prescale & div_mask) == div_mask);
         end
         else
         begin
            timer_tick <= 1'b0;
         end
      end
   end

endmodule // ebtc_tick

// ---- rtl/ebtc_wave.v ----
`timescale 1ns/1ns
`include "ebtc_defines.vh"

module ebtc_wave
(
   input wire hclk,                  // System clock
   input wire hresetn,               // Async reset, active low
   input wire [1:0] mode,            // Waveform mode
   input wire [1:0] action,          // Compare output action
   input wire match_ev,              // Unblocked match on a tick
   input wire force_ev,              // Forced compare pulse
   input wire wrap_ev,               // Tick moving MAX to BOTTOM
   input wire count_down,            // Counter direction
   input wire at_max,                // Counter equals MAX
   input wire at_bottom,             // Counter equals BOTTOM
   output reg compare_output         // Compare output state
);

   reg pc_level;

   // Extreme values pin the phase correct level so MAX gives steady
   // high and BOTTOM steady low in non-inverting use
   always @*
   begin
      pc_level = count_down;
      if (at_max)
         pc_level = 1'b1;
      else if (at_bottom)
         pc_level = 1'b0;
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         compare_output <= 1'b0;
      else if (force_ev || ((mode == `EBTC_MODE_NORMAL ||
               mode == `EBTC_MODE_CLR) && match_ev))
      begin
         case (action)
            `EBTC_ACT_TOGGLE: compare_output <= ~compare_output;
            `EBTC_ACT_CLEAR: compare_output <= 1'b0;
            `EBTC_ACT_SET: compare_output <= 1'b1;
            default: compare_output <= compare_output;
         endcase
      end
      else if (mode == `EBTC_MODE_FAST)
      begin
         // Bottom wins over a coincident match: MAX compare stays set with the clear action, clear with the set action
         if (wrap_ev && action == `EBTC_ACT_CLEAR)
            compare_output <= 1'b1;
         else if (wrap_ev && action == `EBTC_ACT_SET)
            compare_output <= 1'b0;
         else if (match_ev && action == `EBTC_ACT_CLEAR)
            compare_output <= 1'b0;
         else if (match_ev && action == `EBTC_ACT_SET)
            compare_output <= 1'b1;
      end
      else if (mode == `EBTC_MODE_PHASE && match_ev)
      begin
         if (action == `EBTC_ACT_CLEAR)
            compare_output <= pc_level;
         else if (action == `EBTC_ACT_SET)
            compare_output <= ~pc_level;
      end
   end

endmodule // ebtc_wave

// ---- rtl/ebtc_top.v ----
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "ebtc_defines.vh"

module ebtc_top
(
   input wire hclk,              // Bus and timer clock
   input wire hresetn,           // Async reset, active low
   input wire hsel,              // AHB slave select
   input wire [31:0] haddr,      // AHB address
   input wire [1:0] htrans,      // AHB transfer type
   input wire hwrite,            // AHB write
   input wire [2:0] hsize,       // AHB size, words only
   input wire [31:0] hwdata,     // AHB write data
   input wire hready,            // AHB bus ready
   output reg hreadyout,         // AHB slave ready
   output reg hresp,             // AHB response, always OKAY
   output reg [31:0] hrdata,     // AHB read data
   input wire crystal_in_pin,    // Crystal input
   output wire crystal_out_pin,  // Crystal feedback, from flop
   input wire irq_ack_ovf,       // Overflow interrupt serviced
   input wire irq_ack_cmp,       // Compare interrupt serviced
   output reg ovf_irq,           // Overflow interrupt request
   output reg cmp_irq,           // Compare interrupt request
   output wire compare_output    // Compare output, from flop
);

   // ******************************************************************
   // Registers
   // ******************************************************************
   reg [1:0] waveform_mode_select;
   reg [1:0] compare_output_action;
   reg [2:0] clock_source_select;
   reg async_clock_select;
   reg [7:0] timer_count_value;
   reg [7:0] compare_value_a;
   reg [7:0] compare_buffer;
   reg overflow_flag;
   reg compare_match_flag_a;
   reg overflow_irq_enable;
   reg compare_irq_enable_a;
   reg count_down;
   reg match_block;
   reg force_compare_strobe;
   reg wr_pend;
   reg rd_pend;
   reg [7:0] addr_q;

   reg [7:0] next_count;
   reg next_down;
   reg count_clear;
   reg ovf_cond;
   reg [31:0] read_mux;

   wire timer_tick;
   wire take;
   wire wr_ctrl_a;
   wire wr_ctrl;
   wire wr_count;
   wire wr_cmp;
   wire wr_flag;
   wire wr_mask;
   wire pwm;
   wire at_max;
   wire at_bottom;
   wire [7:0] top_value;
   wire at_top;
   wire match;
   wire step;
   wire match_ev;
   wire wrap_ev;
   wire ovf_set;
   wire ovf_clr;
   wire cmp_clr;

   function ebtc_hit;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         ebtc_hit = (addr == ofs);
      end
   endfunction

   function ebtc_is_pwm;
      input [1:0] mode;
      begin
         ebtc_is_pwm = (mode == `EBTC_MODE_PHASE) ||
                       (mode == `EBTC_MODE_FAST);
      end
   endfunction

   // ******************************************************************
   // AHB-Lite slave
   // ******************************************************************
   assign take = hsel & hready & htrans[1];
   assign wr_ctrl_a = wr_pend & ebtc_hit(addr_q, `EBTC_OFS_CTRL_A);
   assign wr_ctrl = wr_pend & ebtc_hit(addr_q, `EBTC_OFS_CTRL);
   assign wr_count = wr_pend & ebtc_hit(addr_q, `EBTC_OFS_COUNT);
   assign wr_cmp = wr_pend & ebtc_hit(addr_q, `EBTC_OFS_CMP_A);
   assign wr_flag = wr_pend & ebtc_hit(addr_q, `EBTC_OFS_FLAG);
   assign wr_mask = wr_pend & ebtc_hit(addr_q, `EBTC_OFS_MASK);

   // Reads take one wait state so the data reflect any write that
   // completed in the cycle just before
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         addr_q <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
      end
      else
      begin
         wr_pend <= take & hwrite;
         rd_pend <= take & ~hwrite;
         hreadyout <= ~(take & ~hwrite);
         hresp <= 1'b0;
         if (take)
            addr_q <= haddr[7:0];
         if (rd_pend)
            hrdata <= read_mux;
      end
   end

   always @*
   begin
      read_mux = 32'h00000000;
      case (addr_q)
         `EBTC_OFS_CTRL_A:
         begin
            read_mux[`EBTC_A_WGM_LSB +: 2] = waveform_mode_select;
            read_mux[`EBTC_A_COM_LSB +: 2] = compare_output_action;
         end
         `EBTC_OFS_CTRL:
         begin
            read_mux[`EBTC_C_CS_LSB +: 3] = clock_source_select;
            read_mux[`EBTC_C_AS_BIT] = async_clock_select;
         end
         `EBTC_OFS_COUNT:
            read_mux[7:0] = timer_count_value;
         `EBTC_OFS_CMP_A:
            read_mux[7:0] = pwm ? compare_buffer :
                            compare_value_a;
         `EBTC_OFS_FLAG:
         begin
            read_mux[`EBTC_F_OVF_BIT] = overflow_flag;
            read_mux[`EBTC_F_CMP_BIT] = compare_match_flag_a;
         end
         `EBTC_OFS_MASK:
         begin
            read_mux[`EBTC_F_OVF_BIT] = overflow_irq_enable;
            read_mux[`EBTC_F_CMP_BIT] = compare_irq_enable_a;
         end
         default:
            read_mux = 32'h00000000;
      endcase
   end

   // ******************************************************************
   // Control and mask registers
   // ******************************************************************
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         waveform_mode_select <= 2'h0;
         compare_output_action <= 2'h0;
         clock_source_select <= 3'h0;
         async_clock_select <= 1'b0;
         overflow_irq_enable <= 1'b0;
         compare_irq_enable_a <= 1'b0;
         force_compare_strobe <= 1'b0;
      end
      else
      begin
         // Strobe reads as zero; only non-PWM modes accept it
         force_compare_strobe <= wr_ctrl_a & hwdata[`EBTC_A_FOC_BIT] &
            ~ebtc_is_pwm(hwdata[`EBTC_A_WGM_LSB +: 2]);
         if (wr_ctrl_a)
         begin
            waveform_mode_select <=
               hwdata[`EBTC_A_WGM_LSB +: 2];
            compare_output_action <= hwdata[`EBTC_A_COM_LSB +: 2];
         end
         if (wr_ctrl)
         begin
            clock_source_select <= hwdata[`EBTC_C_CS_LSB +: 3];
            async_clock_select <= hwdata[`EBTC_C_AS_BIT];
         end
         if (wr_mask)
         begin
            overflow_irq_enable <= hwdata[`EBTC_F_OVF_BIT];
            compare_irq_enable_a <= hwdata[`EBTC_F_CMP_BIT];
         end
      end
   end

   // ******************************************************************
   // Tick source
   // ******************************************************************
   ebtc_tick u_tick
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .clock_source_select(clock_source_select),
      .async_clock_select(async_clock_select),
      .crystal_in_pin(crystal_in_pin),
      .timer_tick(timer_tick),
      .crystal_out_pin(crystal_out_pin)
   );

   // ******************************************************************
   // Counter unit
   // ******************************************************************
   assign pwm = ebtc_is_pwm(waveform_mode_select);
   assign at_max = (timer_count_value == `EBTC_MAX);
   assign at_bottom = (timer_count_value == `EBTC_BOTTOM);
   assign top_value = (waveform_mode_select == `EBTC_MODE_CLR) ?
                      compare_value_a : `EBTC_MAX;
   assign at_top = (timer_count_value == top_value);
   assign step = timer_tick & ~wr_count;

   always @*
   begin
      next_count = timer_count_value + `EBTC_ONE;
      next_down = 1'b0;
      count_clear = 1'b0;
      ovf_cond = at_max;
      case (waveform_mode_select)
         `EBTC_MODE_NORMAL:
            next_count = timer_count_value + `EBTC_ONE;
         `EBTC_MODE_CLR:
         begin
            count_clear = at_top;
            if (count_clear)
               next_count = `EBTC_BOTTOM;
         end
         `EBTC_MODE_PHASE:
         begin
            // Dual slope: turn at MAX, overflow on reaching BOTTOM
            ovf_cond = count_down &&
                       (timer_count_value == `EBTC_ONE);
            if (!count_down && at_max)
            begin
               next_down = 1'b1;
               next_count = timer_count_value - `EBTC_ONE;
            end
            else if (count_down && !at_bottom)
            begin
               next_down = 1'b1;
               next_count = timer_count_value - `EBTC_ONE;
            end
         end
         default:
            next_count = timer_count_value + `EBTC_ONE;
      endcase
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         timer_count_value <= `EBTC_RST_BYTE;
         count_down <= 1'b0;
         match_block <= 1'b0;
      end
      else if (wr_count)
      begin
         timer_count_value <= hwdata[7:0];
         match_block <= 1'b1;
      end
      else if (timer_tick)
      begin
         timer_count_value <= next_count;
         count_down <= next_down;
         match_block <= 1'b0;
      end
   end

   // ******************************************************************
   // Compare unit
   // ******************************************************************
   assign match = (timer_count_value == compare_value_a);
   assign match_ev = step & match & ~match_block;
   assign wrap_ev = step & at_max &
                    (waveform_mode_select == `EBTC_MODE_FAST);

   // A PWM period never sees a half-updated compare value
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         compare_value_a <= `EBTC_RST_BYTE;
         compare_buffer <= `EBTC_RST_BYTE;
      end
      else
      begin
         if (wr_cmp)
            compare_buffer <= hwdata[7:0];
         if (wr_cmp && !pwm)
            compare_value_a <= hwdata[7:0];
         else if (pwm && step && at_max)
            compare_value_a <= compare_buffer;
      end
   end

   // ******************************************************************
   // Flags and interrupt requests
   // ******************************************************************
   assign ovf_set = step & ovf_cond;
   assign ovf_clr = irq_ack_ovf |
                    (wr_flag & hwdata[`EBTC_F_OVF_BIT]);
   assign cmp_clr = irq_ack_cmp |
                    (wr_flag & hwdata[`EBTC_F_CMP_BIT]);

   // A set arriving with a clear is kept
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         overflow_flag <= 1'b0;
         compare_match_flag_a <= 1'b0;
         ovf_irq <= 1'b0;
         cmp_irq <= 1'b0;
      end
      else
      begin
         overflow_flag <= ovf_set | (overflow_flag & ~ovf_clr);
         // Forced compares never reach this flag
         compare_match_flag_a <= match_ev |
            (compare_match_flag_a & ~cmp_clr);
         ovf_irq <= overflow_flag & overflow_irq_enable;
         cmp_irq <= compare_match_flag_a &
                    compare_irq_enable_a;
      end
   end

   // ******************************************************************
   // Waveform generator
   // ******************************************************************
   ebtc_wave u_wave
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .mode(waveform_mode_select),
      .action(compare_output_action),
      .match_ev(match_ev),
      .force_ev(force_compare_strobe),
      .wrap_ev(wrap_ev),
      .count_down(count_down),
      .at_max(at_max),
      .at_bottom(at_bottom),
      .compare_output(compare_output)
   );

endmodule // ebtc_top

// ---- verification/ebtc_top_sva.sv ----
`timescale 1ns/1ns

module ebtc_top_sva
(
   input wire hclk, // Bus clock
   input wire hresetn, // Async reset, active low
   input wire hsel, // Slave select
   input wire [1:0] htrans, // Transfer type
   input wire hwrite, // Write
   input wire hready, // Bus ready
   input wire hreadyout, // Slave ready
   input wire hresp, // Response
   input wire [31:0] hrdata, // Read data
   input wire crystal_in_pin, // Crystal input
   input wire crystal_out_pin, // Crystal feedback
   input wire irq_ack_cmp, // Compare interrupt serviced
   input wire ovf_irq, // Overflow request
   input wire cmp_irq, // Compare request
   input wire compare_output // Compare output
);
   // ****************************************************************
   // Bus and pin checks
   // ****************************************************************
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   wire rd_take = hsel && htrans[1] && hready && !hwrite;
   wire wr_take = hsel && htrans[1] && hready && hwrite;

   AST_RESP_OKAY:
      assert property (hresp == 1'b0) else $error("error response seen");
   AST_READ_WAIT:
      assert property (rd_take |=> !hreadyout ##1 hreadyout)
      else $error("read data phase not two cycles");
   AST_WAIT_ONLY_READ:
      assert property (!rd_take |=> hreadyout)
      else $error("wait state without a read");
   AST_HRDATA_HOLD:
      assert property (!$stable(hrdata) |-> $past(!hreadyout))
      else $error("read data moved outside a read");
   AST_RESET_QUIET:
      assert property ($rose(hresetn) |-> hreadyout && !ovf_irq
         && !cmp_irq && !compare_output && hrdata == 32'h0)
      else $error("outputs not at reset values");
   AST_CMP_ACK:
      assert property (cmp_irq && irq_ack_cmp |=> ##1 !cmp_irq)
      else $error("compare request kept after service");
   // A clear lands one cycle after the ack, a write two after its take
   AST_CMP_IRQ_STICKY:
      assert property (cmp_irq && !$past(irq_ack_cmp) && !$past(wr_take, 2)
         |=> cmp_irq) else $error("compare request dropped alone");
   AST_XTAL_FB:
      assert property ($rose(crystal_in_pin) |-> ##3 $fell(crystal_out_pin))
      else $error("crystal feedback lag wrong");

   COV_READ: cover property (rd_take);
   COV_CMP_IRQ: cover property ($rose(cmp_irq));
   COV_OVF_IRQ: cover property ($rose(ovf_irq));
endmodule // ebtc_top_sva

bind ebtc_top ebtc_top_sva u_sva (.hclk, .hresetn, .hsel, .htrans,
   .hwrite, .hready, .hreadyout, .hresp, .hrdata, .crystal_in_pin,
   .crystal_out_pin, .irq_ack_cmp, .ovf_irq, .cmp_irq, .compare_output);

// ---- verification/ebtc_cpu_model.sv ----
`timescale 1ns/1ns

module ebtc_cpu_model
(
   input wire hclk, // Bus clock
   input wire hready, // Bus ready
   input wire [31:0] hrdata, // Read data
   output logic hsel, // Slave select
   output logic [31:0] haddr, // Address
   output logic [1:0] htrans, // Transfer type
   output logic hwrite, // Write
   output logic [2:0] hsize, // Size, always a word
   output logic [31:0] hwdata // Write data
);
   // ****************************************************************
   // Single word transfers
   // ****************************************************************
   initial
   begin
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // Any register, any time; the master never assumes a latency
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
endmodule // ebtc_cpu_model

// ---- verification/eight_bit_timer_compare_tb.sv ----
`timescale 1ns/1ns

module eight_bit_timer_compare_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic crystal_in_pin = 1'b0;
   logic irq_ack_cmp = 1'b0;
   logic irq_ack_ovf = 1'b0;
   logic hsel, hwrite;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, q;
   logic [9:0] acts = 10'h12D;
   logic [4:0] outs = 5'h13;
   wire [31:0] hrdata;
   wire hreadyout, hresp, crystal_out_pin, ovf_irq, cmp_irq, compare_output;
   int mismatches = 0;
   int compares = 0;
   int i;

   ebtc_top i_ebtc_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .crystal_in_pin, .crystal_out_pin, .irq_ack_ovf, .irq_ack_cmp,
      .ovf_irq, .cmp_irq, .compare_output);
   ebtc_cpu_model cpu (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata);

   always #5 hclk = ~hclk;
   always
   begin
      repeat (4) @(posedge hclk);
      crystal_in_pin <= ~crystal_in_pin;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      cpu.xfer(1'b1, a, d, x);
   endtask
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         $display("wrong value %s: expected %h, seen %h", n, e, g);
         mismatches++;
      end
   endtask
   task automatic rchk(input string n, input logic [7:0] a,
      input logic [31:0] e);
      cpu.xfer(1'b0, a, 32'h0, q);
      chk(n, e, q);
   endtask
   task finish_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial
   begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      for (i = 0; i <= 24; i += 4)
         rchk("reset value", i[7:0], 32'h0);
      $display("test reset done");
      wr(8'h08, 32'hA5);
      wr(8'h0C, 32'h3C);
      rchk("count", 8'h08, 32'hA5);
      rchk("compare", 8'h0C, 32'h3C);
      repeat (20) @(posedge hclk);
      rchk("stopped count", 8'h08, 32'hA5);
      $display("test access done");
      wr(8'h08, 32'hFD);
      wr(8'h14, 32'h1);
      wr(8'h04, 32'h1);
      for (i = 0; i < 200 && ovf_irq !== 1'b1; i++) @(posedge hclk);
      chk("ovf irq", 32'h1, {31'h0, ovf_irq});
      wr(8'h04, 32'h0);
      rchk("ovf flag", 8'h10, 32'h1);
      wr(8'h10, 32'h1);
      rchk("ovf cleared", 8'h10, 32'h0);
      chk("ovf irq low", 32'h0, {31'h0, ovf_irq});
      $display("test overflow done");
      wr(8'h0C, 32'h10);
      wr(8'h08, 32'h10);
      wr(8'h04, 32'h1);
      wr(8'h04, 32'h0);
      rchk("blocked flag", 8'h10, 32'h0);
      $display("test blocking done");
      wr(8'h00, 32'h2);
      wr(8'h0C, 32'h5);
      wr(8'h08, 32'h0);
      wr(8'h14, 32'h2);
      wr(8'h04, 32'h1);
      for (i = 0; i < 200 && cmp_irq !== 1'b1; i++) @(posedge hclk);
      chk("cmp irq", 32'h1, {31'h0, cmp_irq});
      wr(8'h04, 32'h0);
      cpu.xfer(1'b0, 8'h08, 32'h0, q);
      chk("clear count", 32'h1, {31'h0, q[7:0] <= 8'h05});
      rchk("cmp flag", 8'h10, 32'h2);
      wr(8'h10, 32'h0);
      rchk("cmp flag kept", 8'h10, 32'h2);
      @(posedge hclk);
      irq_ack_cmp <= 1'b1;
      @(posedge hclk);
      irq_ack_cmp <= 1'b0;
      rchk("cmp acked", 8'h10, 32'h0);
      chk("cmp irq low", 32'h0, {31'h0, cmp_irq});
      $display("test compare done");
      wr(8'h08, 32'h77);
      for (i = 0; i < 5; i++)
      begin
         wr(8'h00, {24'h0, 2'h2, acts[2*i+:2], 4'h0});
         repeat (3) @(posedge hclk);
         chk("forced output", {31'h0, outs[i]},
            {31'h0, compare_output});
      end
      rchk("force no flag", 8'h10, 32'h0);
      rchk("force no count", 8'h08, 32'h77);
      rchk("strobe reads zero", 8'h00, 32'h10);
      $display("test force done");
      // Fast PWM on crystal ticks: active compare stays 5 until MAX
      wr(8'h00, 32'h23);
      wr(8'h0C, 32'h08);
      rchk("buffer", 8'h0C, 32'h08);
      wr(8'h08, 32'h0);
      wr(8'h04, 32'h9);
      for (i = 0; i < 200 && cmp_irq !== 1'b1; i++) @(posedge hclk);
      chk("xtal irq", 32'h1, {31'h0, cmp_irq});
      wr(8'h04, 32'h0);
      cpu.xfer(1'b0, 8'h08, 32'h0, q);
      chk("old cmp", 32'h1, {31'h0, q[7:0] < 8'h08});
      chk("pwm output", 32'h0, {31'h0, compare_output});
      wr(8'h10, 32'h2);
      rchk("cmp w1c", 8'h10, 32'h0);
      wr(8'h08, 32'hFE);
      wr(8'h04, 32'h9);
      for (i = 0; i < 200 && cmp_irq !== 1'b1; i++) @(posedge hclk);
      wr(8'h04, 32'h0);
      rchk("new cmp", 8'h08, 32'h09);
      rchk("both flags", 8'h10, 32'h3);
      @(posedge hclk);
      irq_ack_ovf <= 1'b1;
      @(posedge hclk);
      irq_ack_ovf <= 1'b0;
      rchk("ovf acked", 8'h10, 32'h2);
      // Three ticks from FE in dual slope: FF, then down to FD
      wr(8'h00, 32'h21);
      wr(8'h08, 32'hFE);
      wr(8'h04, 32'h1);
      wr(8'h04, 32'h0);
      rchk("dual slope", 8'h08, 32'hFD);
      $display("test pwm done");
      finish_test;
   end

   initial
   begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      finish_test;
   end
endmodule // eight_bit_timer_compare_tb
